/* hdl/mwbld_decoder.sv */
/*
 * byte-lane decoder sharing four byte lanes between 8, 16 and 32-bit hosts.
 * assumes host pins are asynchronous to clk and upper address decode
 * arrives already folded into each select input.
 */
// Notes on behaviour
// RULE_01: a byte offset reaches the same stored byte from every host.
// RULE_02: big-endian: byte 0 in bits 31-24, byte 3 in bits 7-0.
// RULE_03: four byte lanes form the word, 8K bytes, own strobes each.
// RULE_04: 32-bit host does word, tri-byte, half and byte transfers.
// RULE_05: strobes active low; word read all reads low, write all writes.
// RULE_06: 32-bit byte access at offset n uses lane three minus n.
// RULE_07: 32-bit host supplies the read/write indication itself.
// RULE_08: host decodes upper address bits to place the region.
// RULE_09: 32-bit transfers end in whole cycles with 0 to 2 stalls.
// RULE_10: 16-bit high data byte serves odd lanes 3 and 1.
// RULE_11: 16-bit address bit 1 low picks lanes 3,2; high picks 1,0.
// RULE_12: 16-bit half access uses both lanes, byte uses strobe lane.
// RULE_13: 8-bit host shares one byte bus; bits 1,0 pick the lane.
// RULE_14: 8-bit byte n reads or writes only lane three minus n.
// RULE_15: 8-bit host feeds its address bits 2-12 to lane address.
// RULE_16: 8-bit host only issues single byte accesses.
// RULE_17: a lane drives on read strobe, stores on write strobe.
// RULE_18: each lane has eleven address bits per port.
// RULE_19: 16-bit host marks bytes with its two data strobes.
// RULE_20: no access signalled means all eight strobes stay high.
// RULE_21: a lane never sees read and write strobes low together.
`timescale 1ns/100ps

module mwbld_decoder #(
   parameter logic [1:0] P32_STALLS = 2'h0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // 32-bit host
   input wire logic p32_sel_n,
   input wire logic p32_read,
   input wire logic [12:0] p32_addr,
   input wire logic [1:0] p32_acc_type,
   input wire logic [31:0] p32_data_in,
   output logic [31:0] p32_data_out,
   output logic p32_data_oe,
   output logic p32_ack,
   output logic [3:0] p32_lane_write_strobe_n,
   output logic [3:0] p32_lane_read_strobe_n,
   // 16-bit host
   input wire logic p16_sel_n,
   input wire logic p16_read,
   input wire logic [12:1] p16_addr,
   input wire logic high_byte_select_n,
   input wire logic low_byte_select_n,
   input wire logic [15:0] p16_data_in,
   output logic [15:0] p16_data_out,
   output logic p16_data_oe,
   output logic [3:0] p16_lane_write_strobe_n,
   output logic [3:0] p16_lane_read_strobe_n,
   // 8-bit host
   input wire logic p8_sel_n,
   input wire logic p8_rd_n,
   input wire logic p8_wr_n,
   input wire logic [12:0] p8_addr,
   input wire logic [7:0] p8_data_in,
   output logic [7:0] p8_data_out,
   output logic p8_data_oe,
   output logic [3:0] p8_lane_write_strobe_n,
   output logic [3:0] p8_lane_read_strobe_n
);

   localparam int SYNC_W = 105;

   // ********************************************************
   // input synchronisers
   // ********************************************************
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync1_reg, sync1_next;
   logic [SYNC_W-1:0] sync2_reg, sync2_next;

   assign raw_in = {p32_sel_n, p32_read, p32_addr, p32_acc_type,
                    p32_data_in, p16_sel_n, p16_read, p16_addr,
                    high_byte_select_n, low_byte_select_n, p16_data_in,
                    p8_sel_n, p8_rd_n, p8_wr_n, p8_addr, p8_data_in};

   always_comb begin
      sync1_next = raw_in;
      sync2_next = sync1_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   logic s32_sel_n, s32_read;
   logic [12:0] s32_addr;
   logic [1:0] s32_type;
   logic [31:0] s32_data;
   logic s16_sel_n, s16_read, s16_hbs_n, s16_lbs_n;
   logic [12:1] s16_addr;
   logic [15:0] s16_data;
   logic s8_sel_n, s8_rd_n, s8_wr_n;
   logic [12:0] s8_addr;
   logic [7:0] s8_data;

   assign {s32_sel_n, s32_read, s32_addr, s32_type, s32_data,
           s16_sel_n, s16_read, s16_addr, s16_hbs_n, s16_lbs_n, s16_data,
           s8_sel_n, s8_rd_n, s8_wr_n, s8_addr, s8_data} = sync2_reg;

   // ********************************************************
   // lane masks
   // ********************************************************
   // offset n sits on lane 3-n; misaligned sizes select nothing
   function automatic logic [3:0] mask32(input logic [1:0] a,
                                         input logic [1:0] t);
      logic [2:0] last;
      logic ok;
      logic [3:0] m;
      last = {1'b0, a} + {1'b0, t};
      ok = (last <= 3'h3) && !(t == mwbld_pkg::ACC_HALF && a[0]);
      m = mwbld_pkg::MASK_NONE;
      for (int i = 0; i < mwbld_pkg::LANES; i++) begin
         if (ok && (3 - i) >= int'(a) && (3 - i) <= int'(last)) begin
            m[i] = 1'b1; // RULE_02 RULE_06
         end
      end
      return m;
   endfunction : mask32

   logic [3:0] m32, m16, m8;
   logic rd8, wr8;

   always_comb begin
      m32 = mask32(s32_addr[1:0], s32_type); // RULE_04
      if (s16_addr[1]) begin // RULE_11
         m16 = (mwbld_pkg::HI_LOWER & {4{!s16_hbs_n}}) |
               (mwbld_pkg::LO_LOWER & {4{!s16_lbs_n}}); // RULE_12
      end else begin
         m16 = (mwbld_pkg::HI_UPPER & {4{!s16_hbs_n}}) |
               (mwbld_pkg::LO_UPPER & {4{!s16_lbs_n}}); // RULE_10
      end
      m8 = mwbld_pkg::BYTE0_LANE >> s8_addr[1:0]; // RULE_13
      // both lines low is no legal cycle, so it selects nothing
      rd8 = !s8_rd_n && s8_wr_n; // RULE_21
      wr8 = !s8_wr_n && s8_rd_n;
   end

   // ********************************************************
   // strobes, lane addresses and write data
   // ********************************************************
   logic [3:0] w32_reg, r32_reg, w16_reg, r16_reg, w8_reg, r8_reg;
   logic [3:0] w32_next, r32_next, w16_next, r16_next, w8_next, r8_next;
   logic [10:0] a32_reg, a16_reg, a8_reg, a32_next, a16_next, a8_next;
   logic [1:0] sel16_reg, sel16_next, sel8_reg, sel8_next;
   logic [31:0] d32_reg, d32_next;
   logic [15:0] d16_reg, d16_next;
   logic [7:0] d8_reg, d8_next;

   always_comb begin
      r32_next = mwbld_pkg::STROBES_IDLE; // RULE_20
      w32_next = mwbld_pkg::STROBES_IDLE;
      r16_next = mwbld_pkg::STROBES_IDLE;
      w16_next = mwbld_pkg::STROBES_IDLE;
      r8_next = mwbld_pkg::STROBES_IDLE;
      w8_next = mwbld_pkg::STROBES_IDLE;
      if (!s32_sel_n) begin // RULE_05
         r32_next = ~(m32 & {4{s32_read}});
         w32_next = ~(m32 & {4{!s32_read}});
      end
      if (!s16_sel_n) begin
         r16_next = ~(m16 & {4{s16_read}});
         w16_next = ~(m16 & {4{!s16_read}});
      end
      if (!s8_sel_n) begin // RULE_14
         r8_next = ~(m8 & {4{rd8}});
         w8_next = ~(m8 & {4{wr8}});
      end
      a32_next = s32_addr[12:2]; // RULE_03
      a16_next = s16_addr[12:2];
      a8_next = s8_addr[12:2];
      sel16_next = {s16_addr[1], 1'b0};
      sel8_next = s8_addr[1:0];
      d32_next = s32_data;
      d16_next = s16_data;
      d8_next = s8_data;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w32_reg <= mwbld_pkg::STROBES_IDLE;
         r32_reg <= mwbld_pkg::STROBES_IDLE;
         w16_reg <= mwbld_pkg::STROBES_IDLE;
         r16_reg <= mwbld_pkg::STROBES_IDLE;
         w8_reg <= mwbld_pkg::STROBES_IDLE;
         r8_reg <= mwbld_pkg::STROBES_IDLE;
         a32_reg <= 11'h000;
         a16_reg <= 11'h000;
         a8_reg <= 11'h000;
         sel16_reg <= 2'h0;
         sel8_reg <= 2'h0;
         d32_reg <= 32'h0000_0000;
         d16_reg <= 16'h0000;
         d8_reg <= 8'h00;
      end else begin
         w32_reg <= w32_next;
         r32_reg <= r32_next;
         w16_reg <= w16_next;
         r16_reg <= r16_next;
         w8_reg <= w8_next;
         r8_reg <= r8_next;
         a32_reg <= a32_next;
         a16_reg <= a16_next;
         a8_reg <= a8_next;
         sel16_reg <= sel16_next;
         sel8_reg <= sel8_next;
         d32_reg <= d32_next;
         d16_reg <= d16_next;
         d8_reg <= d8_next;
      end
   end

   assign p32_lane_write_strobe_n = w32_reg;
   assign p32_lane_read_strobe_n = r32_reg;
   assign p16_lane_write_strobe_n = w16_reg;
   assign p16_lane_read_strobe_n = r16_reg;
   assign p8_lane_write_strobe_n = w8_reg;
   assign p8_lane_read_strobe_n = r8_reg;

   // ********************************************************
   // lane stores
   // ********************************************************
   mwbld_lane_if lane_bus[mwbld_pkg::LANES] ();
   logic [3:0][7:0] rd32, rd16, rd8b;

   for (genvar i = 0; i < mwbld_pkg::LANES; i++) begin : g_lane
      assign lane_bus[i].wr_n = {w8_reg[i], w16_reg[i], w32_reg[i]};
      assign lane_bus[i].rd_n = {r8_reg[i], r16_reg[i], r32_reg[i]};
      assign lane_bus[i].addr = {a8_reg, a16_reg, a32_reg}; // RULE_18
      // odd lanes take the 16-bit high byte, even lanes the low byte
      assign lane_bus[i].wdata = {d8_reg,
                                  (i % 2 == 1) ? d16_reg[15:8]
                                               : d16_reg[7:0],
                                  d32_reg[8*i +: 8]}; // RULE_01
      assign rd32[i] = lane_bus[i].rdata[mwbld_pkg::P32];
      assign rd16[i] = lane_bus[i].rdata[mwbld_pkg::P16];
      assign rd8b[i] = lane_bus[i].rdata[mwbld_pkg::P8];

      mwbld_lane_ram #(
         .DEPTH(mwbld_pkg::DEPTH)
      ) u_ram (
         .clk(clk),
         .bus(lane_bus[i])
      );
   end

   // ********************************************************
   // read data return and 32-bit handshake
   // ********************************************************
   logic [31:0] q32_reg, q32_next;
   logic [15:0] q16_reg, q16_next;
   logic [7:0] q8_reg, q8_next;
   logic oe32_reg, oe32_next, oe16_reg, oe16_next, oe8_reg, oe8_next;
   logic [1:0] cnt_reg, cnt_next;
   logic ack_reg, ack_next;
   logic act32;

   always_comb begin
      act32 = (w32_reg & r32_reg) != mwbld_pkg::STROBES_IDLE;
      oe32_next = r32_reg != mwbld_pkg::STROBES_IDLE; // RULE_17
      oe16_next = r16_reg != mwbld_pkg::STROBES_IDLE;
      oe8_next = r8_reg != mwbld_pkg::STROBES_IDLE;
      q32_next = rd32; // RULE_02
      q16_next = sel16_reg[1] ? {rd16[1], rd16[0]}
                              : {rd16[3], rd16[2]}; // RULE_10
      q8_next = rd8b[2'h3 - sel8_reg]; // RULE_13
      // stalls stretch the cycle in whole clock periods
      if (!act32) begin // RULE_09
         cnt_next = 2'h0;
      end else if (cnt_reg < P32_STALLS) begin
         cnt_next = cnt_reg + 2'h1;
      end else begin
         cnt_next = cnt_reg;
      end
      ack_next = act32 && (cnt_reg == P32_STALLS); // RULE_09
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q32_reg <= 32'h0000_0000;
         q16_reg <= 16'h0000;
         q8_reg <= 8'h00;
         oe32_reg <= 1'b0;
         oe16_reg <= 1'b0;
         oe8_reg <= 1'b0;
         cnt_reg <= 2'h0;
         ack_reg <= 1'b0;
      end else begin
         q32_reg <= q32_next;
         q16_reg <= q16_next;
         q8_reg <= q8_next;
         oe32_reg <= oe32_next;
         oe16_reg <= oe16_next;
         oe8_reg <= oe8_next;
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
      end
   end

   assign p32_data_out = q32_reg;
   assign p16_data_out = q16_reg;
   assign p8_data_out = q8_reg;
   assign p32_data_oe = oe32_reg;
   assign p16_data_oe = oe16_reg;
   assign p8_data_oe = oe8_reg;
   assign p32_ack = ack_reg;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_word_read;
      !s32_sel_n && s32_read && s32_type == mwbld_pkg::ACC_WORD &&
      s32_addr[1:0] == 2'h0;
   endsequence
   sequence s_word_write;
      !s32_sel_n && !s32_read && s32_type == mwbld_pkg::ACC_WORD &&
      s32_addr[1:0] == 2'h0;
   endsequence

   a_word_read: assert property (s_word_read |=> // RULE_05
      r32_reg == 4'h0 && w32_reg == 4'hf)
      else $error("word read strobes wrong");
   a_word_write: assert property (s_word_write |=> // RULE_05
      w32_reg == 4'h0 && r32_reg == 4'hf)
      else $error("word write strobes wrong");
   a_byte32_lane: assert property (!s32_sel_n && // RULE_06
      s32_type == mwbld_pkg::ACC_BYTE |=>
      (w32_reg & r32_reg) == ~(4'h8 >> $past(s32_addr[1:0])))
      else $error("32-bit byte lane wrong");
   a_idle_high: assert property (s32_sel_n && s16_sel_n && // RULE_20
      s8_sel_n |=> (w32_reg & r32_reg & w16_reg & r16_reg &
      w8_reg & r8_reg) == 4'hf)
      else $error("strobe active while idle");
   a_no_clash: assert property (((~w32_reg & ~r32_reg) | // RULE_21
      (~w16_reg & ~r16_reg) | (~w8_reg & ~r8_reg)) == 4'h0)
      else $error("read and write strobe low together");
   a_half_select: assert property (!s16_sel_n |=> // RULE_11
      ($past(s16_addr[1]) ? (w16_reg & r16_reg) | 4'h3
                          : (w16_reg & r16_reg) | 4'hc) == 4'hf)
      else $error("16-bit half select wrong");
   a_half_both: assert property (!s16_sel_n && s16_read && // RULE_12
      !s16_hbs_n && !s16_lbs_n && !s16_addr[1] |=> r16_reg == 4'h3)
      else $error("16-bit half read lanes wrong");
   a_byte8_lane: assert property (!s8_sel_n && !s8_rd_n && // RULE_14
      s8_wr_n |=> r8_reg == ~(4'h8 >> $past(s8_addr[1:0])) &&
      w8_reg == 4'hf)
      else $error("8-bit byte lane wrong");
   a_ack_bound: assert property ($rose(act32) |-> // RULE_09
      !ack_reg ##1 (act32 throughout ##[0:2] ack_reg))
      else $error("32-bit acknowledge late");
   a_read_oe: assert property (r8_reg != 4'hf |=> // RULE_17
      p8_data_oe && p8_data_out == rd8b[2'h3 - $past(sel8_reg)])
      else $error("8-bit read data not returned");

endmodule : mwbld_decoder

/* hdl/mwbld_pkg.sv */
/*
 * constants shared by the byte-lane decoder and its lane storage.
 * assumes a single 20 MHz clock and a 32-bit big-endian shared word.
 */
package mwbld_pkg;

   // ********************************************************
   // geometry
   // ********************************************************
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int LANE_AW = 11;
   localparam int BYTE_AW = 13;
   localparam int DEPTH = 2048;
   localparam int PORTS = 3;

   // host port index into the lane buses
   localparam int P32 = 0;
   localparam int P16 = 1;
   localparam int P8 = 2;

   // ********************************************************
   // 32-bit host access type codes
   // ********************************************************
   localparam logic [1:0] ACC_BYTE = 2'h0;
   localparam logic [1:0] ACC_HALF = 2'h1;
   localparam logic [1:0] ACC_TRI = 2'h2;
   localparam logic [1:0] ACC_WORD = 2'h3;

   // ********************************************************
   // lane masks and strobe levels
   // ********************************************************
   localparam logic [3:0] STROBES_IDLE = 4'hf;
   localparam logic [3:0] MASK_NONE = 4'h0;
   localparam logic [3:0] HALF_UPPER = 4'hc;
   localparam logic [3:0] HALF_LOWER = 4'h3;
   localparam logic [3:0] HI_UPPER = 4'h8;
   localparam logic [3:0] HI_LOWER = 4'h2;
   localparam logic [3:0] LO_UPPER = 4'h4;
   localparam logic [3:0] LO_LOWER = 4'h1;
   localparam logic [3:0] BYTE0_LANE = 4'h8;

   // ********************************************************
   // timing
   // ********************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int CYCLE_NS = 50;
   localparam int CYCLE_CLKS = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] MAX_STALLS = 2'h2;

endpackage : mwbld_pkg

/* hdl/mwbld_lane_if.sv */
/*
 * per-lane bundle between the decoder and one byte-wide lane store.
 * assumes one strobe pair, address, and data pair for each host port.
 */
`timescale 1ns/100ps

interface mwbld_lane_if;
   logic [mwbld_pkg::PORTS-1:0] wr_n;
   logic [mwbld_pkg::PORTS-1:0] rd_n;
   logic [mwbld_pkg::PORTS-1:0][mwbld_pkg::LANE_AW-1:0] addr;
   logic [mwbld_pkg::PORTS-1:0][mwbld_pkg::LANE_W-1:0] wdata;
   logic [mwbld_pkg::PORTS-1:0][mwbld_pkg::LANE_W-1:0] rdata;

   modport ctl (output wr_n, rd_n, addr, wdata, input rdata);
   modport ram (input wr_n, rd_n, addr, wdata, output rdata);
endinterface : mwbld_lane_if

/* hdl/mwbld_lane_ram.sv */
/*
 * one byte-wide lane store with one port per host.
 * assumes strobes and addresses arrive registered on clk.
 */
`timescale 1ns/100ps

module mwbld_lane_ram #(
   parameter int DEPTH = mwbld_pkg::DEPTH
) (
   // clock
   input wire logic clk,
   // lane bundle
   mwbld_lane_if.ram bus
);

   logic [mwbld_pkg::LANE_W-1:0] mem_reg [DEPTH];
   logic [mwbld_pkg::LANE_W-1:0] mem_next [DEPTH];

   // ********************************************************
   // write path
   // ********************************************************
   // the 32-bit host is applied last, so it wins a same-byte collision
   always_comb begin
      mem_next = mem_reg;
      for (int p = mwbld_pkg::PORTS - 1; p >= 0; p--) begin
         if (!bus.wr_n[p] && bus.rd_n[p]) begin
            mem_next[bus.addr[p]] = bus.wdata[p]; // RULE_17
         end
      end
   end

   // storage holds no reset; contents are undefined at power-up
   always_ff @(posedge clk) begin
      mem_reg <= mem_next;
   end

   // ********************************************************
   // read path
   // ********************************************************
   always_comb begin
      for (int p = 0; p < mwbld_pkg::PORTS; p++) begin
         bus.rdata[p] = mem_reg[bus.addr[p]]; // RULE_18
      end
   end

endmodule : mwbld_lane_ram

/* tb/mwbld_host_model.sv */
/*
 * stand-in for the control side of the 32, 16 and 8-bit hosts.
 * assumes the bench changes its requests just after a rising edge.
 */
`timescale 1ns/100ps

module mwbld_host_model #(
   parameter logic [2:0] REGION = 3'h1
) (
   // requests from the bench
   input wire logic [2:0] req,
   input wire logic [2:0] rd,
   input wire logic [15:0] addr,
   input wire logic [1:0] acc,
   input wire logic [1:0] bs_n,
   input wire logic bad8,
   // 32-bit host pins
   output logic p32_sel_n,
   output logic p32_read,
   output logic [12:0] p32_addr,
   output logic [1:0] p32_acc_type,
   // 16-bit host pins
   output logic p16_sel_n,
   output logic p16_read,
   output logic [12:1] p16_addr,
   output logic high_byte_select_n,
   output logic low_byte_select_n,
   // 8-bit host pins
   output logic p8_sel_n,
   output logic p8_rd_n,
   output logic p8_wr_n,
   output logic [12:0] p8_addr
);
   // ********************************************************
   // upper decode and control pins
   // ********************************************************
   logic [2:0] hit;

   // placement is the host's job, so the decoder only sees a select
   assign hit = req & {3{addr[15:13] == REGION}};
   assign p32_sel_n = !hit[0];
   assign p32_read = rd[0];
   assign p32_addr = addr[12:0];
   assign p32_acc_type = acc;
   assign p16_sel_n = !hit[1];
   assign p16_read = rd[1];
   // no bit 0 on this host: the two strobes pick the byte
   assign p16_addr = addr[12:1];
   assign high_byte_select_n = bs_n[1];
   assign low_byte_select_n = bs_n[0];
   assign p8_sel_n = !hit[2];
   // only single bytes; bad8 pulls both lines low on purpose
   assign p8_rd_n = !(hit[2] && (rd[2] || bad8));
   assign p8_wr_n = !(hit[2] && (!rd[2] || bad8));
   assign p8_addr = addr[12:0];
endmodule : mwbld_host_model

/* tb/mwbld_decoder_bench.sv */
/*
 * self-checking bench for the byte-lane decoder and its lanes.
 * assumes the host model above and the shared package.
 */
`timescale 1ns/100ps

module mwbld_decoder_bench;
   // ********************************************************
   // clock, stimulus and observed pins
   // ********************************************************
   localparam logic [1:0] STALLS = 2'h2;
   localparam logic [12:0] BASE = 13'h0040;
   localparam logic [15:0] HB = 16'h2040;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] req = 3'h0;
   logic [2:0] rd = 3'h0;
   logic [15:0] addr = 16'h0;
   logic [1:0] acc = 2'h0;
   logic [1:0] bs_n = 2'h3;
   logic bad8 = 1'b0;
   logic [31:0] d32 = 32'h0;
   logic [15:0] d16 = 16'h0;
   logic [7:0] d8 = 8'h0;
   wire logic s32, r32, s16, r16, hb_n, lb_n, s8, rd8_n, wr8_n;
   wire logic [12:0] a32, a8;
   wire logic [12:1] a16;
   wire logic [1:0] t32;
   logic [31:0] q32;
   logic [15:0] q16;
   logic [7:0] q8;
   logic q32_oe, q16_oe, q8_oe, ack;
   logic [3:0] w32, rr32, w16, rr16, w8, rr8;
   logic [7:0] shadow [0:8191];
   int n_fail = 0;
   int comparisons = 0;

   always #25 clk = ~clk;

   mwbld_host_model i_mwbld_host_model (.req(req), .rd(rd), .addr(addr),
      .acc(acc), .bs_n(bs_n), .bad8(bad8), .p32_sel_n(s32), .p32_read(r32),
      .p32_addr(a32), .p32_acc_type(t32), .p16_sel_n(s16), .p16_read(r16),
      .p16_addr(a16), .high_byte_select_n(hb_n), .low_byte_select_n(lb_n),
      .p8_sel_n(s8), .p8_rd_n(rd8_n), .p8_wr_n(wr8_n), .p8_addr(a8));

   mwbld_decoder #(.P32_STALLS(STALLS)) i_mwbld_decoder (.clk(clk),
      .rstn(rstn), .p32_sel_n(s32), .p32_read(r32), .p32_addr(a32),
      .p32_acc_type(t32), .p32_data_in(d32), .p32_data_out(q32),
      .p32_data_oe(q32_oe), .p32_ack(ack), .p32_lane_write_strobe_n(w32),
      .p32_lane_read_strobe_n(rr32), .p16_sel_n(s16), .p16_read(r16),
      .p16_addr(a16), .high_byte_select_n(hb_n), .low_byte_select_n(lb_n),
      .p16_data_in(d16), .p16_data_out(q16), .p16_data_oe(q16_oe),
      .p16_lane_write_strobe_n(w16), .p16_lane_read_strobe_n(rr16),
      .p8_sel_n(s8), .p8_rd_n(rd8_n), .p8_wr_n(wr8_n), .p8_addr(a8),
      .p8_data_in(d8), .p8_data_out(q8), .p8_data_oe(q8_oe),
      .p8_lane_write_strobe_n(w8), .p8_lane_read_strobe_n(rr8));

   // ********************************************************
   // shared helpers
   // ********************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   // lanes covered by a 32-bit access; misaligned ones get none
   function automatic logic [3:0] m32(input logic [1:0] a,
                                      input logic [1:0] t);
      logic [3:0] b;
      logic ok;
      b = 4'hf << (2'h3 - t);
      ok = t == 2'h0 || (t == 2'h1 && !a[0]) || (t == 2'h2 && a <= 2'h1)
           || (t == 2'h3 && a == 2'h0);
      return ok ? b >> a : 4'h0;
   endfunction : m32

   // strobes land three edges after the pins, data one later, plus stalls
   task automatic go(input int p, input logic [15:0] a, input logic [1:0] t,
                     input logic r, input logic [31:0] wd,
                     input logic [1:0] bs, input logic bad);
      @(posedge clk);
      req <= 3'h1 << p;
      rd <= {3{r}};
      addr <= a;
      acc <= t;
      bs_n <= bs;
      bad8 <= bad;
      // a host that is not writing leaves its data lines toggling
      d32 <= (p == 0 && !r) ? wd : ~d32;
      d16 <= (p == 1 && !r) ? wd[15:0] : ~d16;
      d8 <= (p == 2 && !r) ? wd[7:0] : ~d8;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : go

   task automatic rel;
      @(posedge clk);
      req <= 3'h0;
      bs_n <= 2'h3;
      bad8 <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({8'h0, w32, rr32, w16, rr16, w8, rr8}, 32'h00ffffff);
   endtask : rel

   task automatic op32(input logic [1:0] a, input logic [1:0] t,
                       input logic r, input logic [31:0] wd);
      logic [3:0] m;
      logic [31:0] bm;
      logic [31:0] e;
      m = m32(a, t);
      go(0, HB + 16'(a), t, r, wd, 2'h3, 1'b0);
      check({w32, rr32}, r ? {4'hf, ~m} : {~m, 4'hf});
      for (int i = 0; i < 4; i++) begin
         bm[8 * i +: 8] = {8{m[i]}};
         if (m[i] && !r) shadow[BASE + 3 - i] = wd[8 * i +: 8];
         e[8 * i +: 8] = shadow[BASE + 3 - i];
      end
      if (m != 4'h0) begin
         check(q32 & bm, e & bm);
         check({q32_oe, ack}, r ? 32'h3 : 32'h1);
      end
      rel();
   endtask : op32

   // ********************************************************
   // scenarios
   // ********************************************************
   task automatic t_p32;
      for (int r = 0; r < 2; r++) begin
         for (int t = 3; t >= 0; t--) begin
            for (int a = 0; a < 4; a++) begin
               op32(2'(a), 2'(t), 1'(r), 32'h40506070 + {4{8'(4 * t + a)}});
            end
         end
      end
   endtask : t_p32

   task automatic t_stall;
      int ks;
      int ka;
      ks = 0;
      ka = 0;
      @(posedge clk);
      req <= 3'h1;
      rd <= 3'h7;
      addr <= HB;
      acc <= 2'h3;
      for (int n = 1; n <= 20 && ka == 0; n++) begin
         @(negedge clk);
         if (ks == 0 && rr32 !== 4'hf) ks = n;
         if (ack === 1'b1) ka = n;
      end
      if (ka == 0) begin
         check(32'h0, 32'h1);
         close_out();
      end
      check(32'(ka - ks), 32'h1 + 32'(STALLS));
      rel();
   endtask : t_stall

   task automatic t_p16;
      logic [3:0] m;
      logic [15:0] wd;
      int ln;
      for (int r = 0; r < 2; r++) begin
         for (int h = 0; h < 2; h++) begin
            for (int b = 0; b < 4; b++) begin
               // b bit 1 releases the high strobe, bit 0 the low one
               m = {~b[1], ~b[0], ~b[1], ~b[0]} & (h ? 4'h3 : 4'hc);
               wd = 16'ha0b0 + 16'(16 * b + h);
               go(1, HB + 16'(2 * h), 2'h0, 1'(r), 32'(wd), 2'(b), 1'b0);
               check({w16, rr16}, r ? {4'hf, ~m} : {~m, 4'hf});
               check(32'(q16_oe), 32'(r != 0 && m != 4'h0));
               for (int j = 0; j < 2; j++) begin
                  ln = 3 - 2 * h - j;
                  if (m[ln] && !r) shadow[BASE + 2 * h + j] = wd[8 - 8 * j +: 8];
                  if (m[ln] && r) check(q16[8 - 8 * j +: 8], shadow[BASE + 2 * h + j]);
               end
               rel();
            end
         end
      end
      op32(2'h0, 2'h3, 1'b1, 32'h0);
   endtask : t_p16

   task automatic t_p8;
      logic [3:0] m;
      for (int r = 0; r < 2; r++) begin
         for (int a = 0; a < 4; a++) begin
            m = 4'h8 >> a;
            go(2, HB + 16'(a), 2'h0, 1'(r), 32'hc0 + 32'(a), 2'h3, 1'b0);
            check({w8, rr8}, r ? {4'hf, ~m} : {~m, 4'hf});
            check(32'(q8_oe), 32'(r));
            if (!r) shadow[BASE + a] = 8'hc0 + 8'(a);
            else check(q8, shadow[BASE + a]);
            rel();
         end
      end
      // both control lines low, then an address outside the region
      go(2, HB, 2'h0, 1'b0, 32'h5a, 2'h3, 1'b1);
      check({w8, rr8}, 32'hff);
      rel();
      go(2, 16'h4040, 2'h0, 1'b0, 32'h77, 2'h3, 1'b0);
      check({w8, rr8}, 32'hff);
      rel();
      op32(2'h0, 2'h3, 1'b1, 32'h0);
   endtask : t_p8

   initial begin
      repeat (10) @(posedge clk);
      check({ack, q32_oe, q16_oe, q8_oe, w32, rr32, w16, rr16, w8, rr8},
            32'h00ffffff);
      rstn <= 1'b1;
      t_p32();
      t_stall();
      t_p16();
      t_p8();
      close_out();
   end
endmodule : mwbld_decoder_bench
